// ===== rtl/tsc_clock_slew.sv
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module tsc_clock_slew
  import tsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tsc_pkg::TSC_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Relaxation oscillator front end
  input wire logic relax_osc_in,
  output logic [1:0] osc_current_range,
  // Normal sense outputs per pin
  input wire logic [1:0] sense_out_normal,
  // Output pins: port0 then port1
  output logic [1:0] sense_pin_out,
  output logic [1:0] sense_pin_oe_n,
  // Clock observation
  output logic prescale_out,
  output logic seq_out
);

  // =====================================================
  // Register decode
  // Slot within the four-word window; only meaningful once mapped
  function automatic logic [1:0] reg_sel(
    input logic [TSC_AW-1:0] adr
  );
    logic [9:0] idx;
    idx = adr[TSC_AW-1:2] - TSC_IDX_SLEW;
    reg_sel = idx[1:0];
  endfunction : reg_sel

  function automatic logic is_mapped(
    input logic [TSC_AW-1:0] adr
  );
    is_mapped = (adr[TSC_AW-1:2] >= TSC_IDX_SLEW)
      && (adr[TSC_AW-1:2] <= TSC_IDX_STAT)
      && (adr[1:0] == 2'h0);
  endfunction : is_mapped

  logic [7:0] fast_slew_control;
  logic [7:0] sequence_prescale_control;
  logic [7:0] sense_aux_control;
  logic bus_req;
  logic bus_wr;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0]
    && is_mapped(wb_adr_i);

  // =====================================================
  // Control field views
  logic boost_interval_enable;
  logic [6:0] boost_interval_count;
  logic route_clock;
  logic sense_clock_invert;
  logic seq_length_select;
  logic seq_gen_enable;
  logic divider_bypass;
  logic [2:0] divider_ratio_select;
  logic [1:0] range_programmed;
  logic cap_sigma_delta_mode;
  logic delta_mode_clock_source;
  logic [1:0] sense_clock_choice;
  logic [1:0] pin_out_select;

  assign boost_interval_enable = fast_slew_control[TSC_SLEW_EN_BIT];
  assign boost_interval_count =
    fast_slew_control[TSC_SLEW_CNT_LSB +: TSC_SLEW_CNT_W];
  assign route_clock = sequence_prescale_control[TSC_SEQ_ROUTE_BIT];
  assign sense_clock_invert =
    sequence_prescale_control[TSC_SEQ_INV_BIT];
  assign seq_length_select = sequence_prescale_control[TSC_SEQ_LEN_BIT];
  assign seq_gen_enable = sequence_prescale_control[TSC_SEQ_EN_BIT];
  assign divider_bypass = sequence_prescale_control[TSC_SEQ_BYP_BIT];
  assign divider_ratio_select =
    sequence_prescale_control[TSC_SEQ_DIV_LSB +: 3];
  assign range_programmed = sense_aux_control[TSC_AUX_RANGE_LSB +: 2];
  assign cap_sigma_delta_mode = sense_aux_control[TSC_AUX_DELTA_BIT];
  assign delta_mode_clock_source = sense_aux_control[TSC_AUX_DSRC_BIT];
  assign sense_clock_choice = sense_aux_control[TSC_AUX_CHOICE_LSB +: 2];
  assign pin_out_select = {sense_aux_control[TSC_AUX_PORT1_BIT],
    sense_aux_control[TSC_AUX_PORT0_BIT]};

  // =====================================================
  // Register writes; only byte lane 0 carries data
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fast_slew_control <= TSC_SLEW_RST;
      sequence_prescale_control <= TSC_SEQ_RST;
      sense_aux_control <= TSC_AUX_RST;
    end
    else if (bus_wr)
    begin
      unique case (reg_sel(wb_adr_i))
        2'h0: fast_slew_control <= wb_dat_i[7:0];
        2'h1: sequence_prescale_control <= wb_dat_i[7:0];
        2'h2: sense_aux_control <= wb_dat_i[7:0];
        2'h3: ;  // Status word is read only
      endcase
    end
  end

  // =====================================================
  // Oscillator edge input: three stages, accepted on agreement
  logic [2:0] relax_sync;
  logic relax_level;
  logic relax_edge;

  // Shift chain and accepted level move together
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      relax_sync <= 3'h0;
      relax_level <= 1'b0;
    end
    else
    begin
      relax_sync <= {relax_sync[1:0], relax_osc_in};
      if (relax_sync[1] == relax_sync[2])
      begin
        relax_level <= relax_sync[2];  // Only once stages two and three agree
      end
    end
  end

  assign relax_edge = (relax_sync[1] == relax_sync[2])
    && (relax_sync[2] != relax_level);

  // =====================================================
  // Boost interval down-counter on the main oscillator clock
  logic [6:0] boost_count;
  logic boost_active;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      boost_count <= 7'h00;
    end
    else if (!boost_interval_enable)
    begin
      boost_count <= 7'h00;
    end
    else if (relax_edge)
    begin
      boost_count <= boost_interval_count;
    end
    else if (boost_count != 7'h00)
    begin
      boost_count <= boost_count - 7'h01;
    end
  end

  // Active for exactly N cycles after a load of N
  assign boost_active = boost_interval_enable
    && (boost_count != 7'h00);

  // Registered so the analog control never glitches
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_current_range <= 2'h0;
    end
    else if (boost_active)
    begin
      osc_current_range <= TSC_RANGE_MAX;
    end
    else
    begin
      osc_current_range <= range_programmed;
    end
  end

  // =====================================================
  // Prescaler; the bypassed path toggles every cycle, the
  // nearest a flop-based output can get to the raw clock
  logic [TSC_DIV_W-1:0] div_count;
  logic div_prev;
  logic div_bit;
  logic prescale_tick;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_count <= 8'h00;
    end
    else
    begin
      div_count <= div_count + 8'h01;
    end
  end

  // Code k taps bit k, a divide by 2^(k+1)
  assign div_bit = div_count[divider_ratio_select];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_prev <= 1'b0;
      prescale_out <= 1'b0;
    end
    else
    begin
      div_prev <= div_bit;
      prescale_out <= divider_bypass ? !prescale_out : div_bit;
    end
  end

  // One generator step per prescaler output period; one step every cycle when bypassed
  assign prescale_tick = divider_bypass
    || (div_bit && !div_prev);

  // =====================================================
  // Pseudo-random sequence generators, 8 and 12 bit
  logic [7:0] lfsr8;
  logic [11:0] lfsr12;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lfsr8 <= TSC_SEQ_SEED[7:0];
      lfsr12 <= TSC_SEQ_SEED;
    end
    else if (!seq_gen_enable)
    begin
      lfsr8 <= TSC_SEQ_SEED[7:0];  // Restart cleanly on enable
      lfsr12 <= TSC_SEQ_SEED;
    end
    else if (prescale_tick)
    begin
      lfsr8 <= {lfsr8[6:0],
        lfsr8[7] ^ lfsr8[5] ^ lfsr8[4] ^ lfsr8[3]};
      lfsr12 <= {lfsr12[10:0],
        lfsr12[11] ^ lfsr12[5] ^ lfsr12[3] ^ lfsr12[0]};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seq_out <= 1'b0;
    end
    else if (!seq_gen_enable)
    begin
      seq_out <= 1'b0;
    end
    else
    begin
      seq_out <= seq_length_select ? lfsr12[11] : lfsr8[7];
    end
  end

  // =====================================================
  // Sense clock selection and pin routing
  logic sense_clock;
  logic pin_clock;

  always_comb
  begin
    if (cap_sigma_delta_mode)
    begin
      sense_clock = delta_mode_clock_source ? seq_out : prescale_out;
    end
    else
    begin
      unique case (sense_clock_choice)
        2'h0: sense_clock = prescale_out;
        2'h1: sense_clock = seq_out;
        2'h2: sense_clock = relax_level;
        2'h3: sense_clock = 1'b0;
      endcase
    end
  end

  // Zero selects the inverted clock
  assign pin_clock = sense_clock_invert ? sense_clock
    : !sense_clock;

  // Pin drivers share one form per port
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_pin
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          sense_pin_out[gp] <= 1'b0;
          sense_pin_oe_n[gp] <= 1'b1;
        end
        else if (route_clock && pin_out_select[gp])
        begin
          sense_pin_out[gp] <= pin_clock;
          sense_pin_oe_n[gp] <= 1'b0;
        end
        else
        begin
          sense_pin_out[gp] <= sense_out_normal[gp];
          sense_pin_oe_n[gp] <= 1'b0;
        end
      end
    end
  endgenerate

  // =====================================================
  // Bus answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i && is_mapped(wb_adr_i))
      begin
        unique case (reg_sel(wb_adr_i))
          2'h0: wb_dat_o[7:0] <= fast_slew_control;
          2'h1: wb_dat_o[7:0] <= sequence_prescale_control;
          2'h2: wb_dat_o[7:0] <= sense_aux_control;
          2'h3: wb_dat_o[7:0] <= {3'h0, seq_out, prescale_out,
            relax_level, boost_active, 1'b0};
        endcase
      end
    end
  end

endmodule : tsc_clock_slew

// ===== rtl/tsc_pkg.sv
package tsc_pkg;
  // =====================================================
  // Register indices; byte address is four times these
  localparam logic [9:0] TSC_IDX_SLEW = 10'h0A8;
  localparam logic [9:0] TSC_IDX_SEQ = 10'h0A9;
  localparam logic [9:0] TSC_IDX_AUX = 10'h0AA;
  localparam logic [9:0] TSC_IDX_STAT = 10'h0AB;
  localparam int TSC_AW = 12;

  // =====================================================
  // Reset values
  localparam logic [7:0] TSC_SLEW_RST = 8'h00;
  localparam logic [7:0] TSC_SEQ_RST = 8'h00;
  localparam logic [7:0] TSC_AUX_RST = 8'h00;

  // =====================================================
  // Fast slew control fields
  localparam int TSC_SLEW_EN_BIT = 0;
  localparam int TSC_SLEW_CNT_LSB = 1;
  localparam int TSC_SLEW_CNT_W = 7;

  // =====================================================
  // Sequence and prescale control fields
  localparam int TSC_SEQ_ROUTE_BIT = 7;
  localparam int TSC_SEQ_INV_BIT = 6;
  localparam int TSC_SEQ_LEN_BIT = 5;
  localparam int TSC_SEQ_EN_BIT = 4;
  localparam int TSC_SEQ_BYP_BIT = 3;
  localparam int TSC_SEQ_DIV_LSB = 0;

  // =====================================================
  // Auxiliary control fields
  localparam int TSC_AUX_RANGE_LSB = 0;
  localparam int TSC_AUX_DELTA_BIT = 2;
  localparam int TSC_AUX_DSRC_BIT = 3;
  localparam int TSC_AUX_CHOICE_LSB = 4;
  localparam int TSC_AUX_PORT0_BIT = 6;
  localparam int TSC_AUX_PORT1_BIT = 7;

  // =====================================================
  // Widths and constants
  localparam int TSC_DIV_W = 8;
  localparam int TSC_SEQ_W = 12;
  localparam logic [1:0] TSC_RANGE_MAX = 2'h3;
  localparam logic [11:0] TSC_SEQ_SEED = 12'h001;
endpackage : tsc_pkg

// ===== sim/tsc_clock_slew_monitor.sv
`timescale 1ns/1ps
// ==========
// Port checks: boost, prescale, pins
module tsc_clock_slew_monitor
(
  // Clock, reset, bus
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tsc_pkg::TSC_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Oscillator, pins, clocks
  input wire logic relax_osc_in,
  input wire logic [1:0] osc_current_range,
  input wire logic [1:0] sense_out_normal,
  input wire logic [1:0] sense_pin_out,
  input wire logic prescale_out,
  input wire logic seq_out
);
  import tsc_pkg::*;
  logic [7:0] s_sl, s_sq, s_ax, hi_len, run_len;
  logic [9:0] idle;
  logic retrig, ps_q, wr_ok;
  logic forced;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  assign wr_ok = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign forced = osc_current_range == 2'h3;
  // Shadow registers, so the rules can be judged from the pins
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      s_sl <= 8'h00;
      s_sq <= 8'h00;
      s_ax <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (wb_adr_i == {TSC_IDX_SLEW, 2'b00})
        s_sl <= wb_dat_i[7:0];
      if (wb_adr_i == {TSC_IDX_SEQ, 2'b00})
        s_sq <= wb_dat_i[7:0];
      if (wb_adr_i == {TSC_IDX_AUX, 2'b00})
        s_ax <= wb_dat_i[7:0];
    end
  // Quiet time and run lengths; a retrigger voids the length check
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      idle <= 10'h000;
      hi_len <= 8'h00;
      run_len <= 8'h00;
      ps_q <= 1'b0;
      retrig <= 1'b0;
    end
    else
    begin
      idle <= (wr_ok || $changed(relax_osc_in)) ? 10'h000 : idle + 10'(idle != 10'h3FF);
      hi_len <= forced ? hi_len + 8'h01 : 8'h00;
      retrig <= forced && (retrig || $changed(relax_osc_in));
      ps_q <= prescale_out;
      run_len <= (prescale_out != ps_q) ? 8'h01 : run_len + 8'h01;
    end
  // Edge seen while boosting is armed, then forced range
  sequence s_arm;
    $changed(relax_osc_in) && s_sl[0] && s_sl[7:1] != 7'h00 && idle >= 10'd2;
  endsequence
  sequence s_boost;
    ##[2:8] forced;
  endsequence
  AST_BOOST_START: assert property (s_arm |-> s_boost)
    else $error("Range not forced after edge");
  AST_BOOST_LEN: assert property ($fell(forced) && s_ax[1:0] != 2'h3
    && !retrig |-> hi_len == {1'b0, s_sl[7:1]})
    else $error("Forced interval length wrong");
  AST_RANGE_REST: assert property (idle >= 10'd140
    |-> osc_current_range == s_ax[1:0])
    else $error("Range not programmed value at rest");
  AST_PIN_NORMAL: assert property (!(s_sq[7] && s_ax[6])
    |=> sense_pin_out[0] == $past(sense_out_normal[0]))
    else $error("Pin not normal value");
  AST_PIN_CLOCK: assert property (s_sq[7] && s_ax[6] && !s_ax[2] && s_ax[5:4] == 2'h0
    |=> sense_pin_out[0] == ($past(prescale_out) ^ !$past(s_sq[6])))
    else $error("Pin not routed clock");
  AST_SEQ_OFF: assert property ((!s_sq[4]) [*3] |-> !seq_out)
    else $error("Generator output not low");
  AST_BYPASS: assert property (s_sq[3] [*2] |-> prescale_out != $past(prescale_out))
    else $error("Bypass clock not toggling");
  AST_DIV_PHASE: assert property (idle >= 10'd600 && !s_sq[3] && $changed(prescale_out)
    |-> run_len == (8'h01 << s_sq[2:0]))
    else $error("Divider phase length wrong");
endmodule : tsc_clock_slew_monitor

bind tsc_clock_slew tsc_clock_slew_monitor u_mon (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .relax_osc_in, .osc_current_range,
  .sense_out_normal, .sense_pin_out, .prescale_out, .seq_out);

// ===== sim/tsc_osc_model.sv
`timescale 1ns/1ps
// ==========
// Oscillator stand-in: one edge per kick
module tsc_osc_model
(
  // Clock and trigger
  input wire logic clk_sys,
  input wire logic kick,
  // Level toward the block
  output logic relax_osc_in
);
  // Starts low; edges only on request so counts stay exact
  initial relax_osc_in = 1'b0;
  // Flip the level just after the edge
  always @(posedge clk_sys)
    if (kick)
      relax_osc_in <= ~relax_osc_in;
endmodule : tsc_osc_model

// ===== sim/tsc_clock_slew_test.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench
module tsc_clock_slew_test;
  import tsc_pkg::*;
  localparam logic [11:0] A_SL = {TSC_IDX_SLEW, 2'b00};
  localparam logic [11:0] A_SQ = {TSC_IDX_SEQ, 2'b00};
  localparam logic [11:0] A_AX = {TSC_IDX_AUX, 2'b00};
  logic clk_sys, reset_n, cyc, stb, we, ack, kick, osc, ps, sq;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat_o, rdat;
  logic [1:0] rng, nrm, pin, oe_n;
  int n_fail, compares, ticks;
  tsc_clock_slew uut (.clk_sys, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .relax_osc_in(osc), .osc_current_range(rng), .sense_out_normal(nrm),
    .sense_pin_out(pin), .sense_pin_oe_n(oe_n), .prescale_out(ps), .seq_out(sq));
  tsc_osc_model u_osc (.clk_sys, .kick, .relax_osc_in(osc));
  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Hang guard, about three times the expected run
  always @(posedge clk_sys)
  begin
    ticks <= ticks + 1;
    if (ticks == 40000)
    begin
      n_fail++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; data taken at the ack edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= s;
    do
      @(posedge clk_sys);
    while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(rdat, {24'h0, e});
  endtask : rd
  task automatic pulse;
    kick <= 1'b1;
    @(posedge clk_sys);
    kick <= 1'b0;
  endtask : pulse
  task automatic t_regs;
    rd(A_SL, TSC_SLEW_RST);
    rd(A_SQ, TSC_SEQ_RST);
    rd(12'h000, 8'h00);
    wr(A_SQ, 8'hA5);
    bus(1'b1, A_SQ, 8'h5A, 4'h0);
    rd(A_SQ, 8'hA5);
  endtask : t_regs
  // Count forced cycles after one edge
  task automatic boost(input logic [7:0] cfg, input int n);
    int k;
    wr(A_SL, cfg);
    pulse;
    k = 0;
    repeat (200)
    begin
      @(posedge clk_sys);
      k += (rng === 2'h3);
    end
    chk(32'(k), 32'(n));
  endtask : boost
  task automatic t_boost;
    boost(8'h03, 1);
    boost(8'h0B, 5);
    boost(8'hFF, 127);
    boost(8'h01, 0);
    boost(8'h0A, 0);
    wr(A_SL, 8'hFF);
    pulse;
    repeat (10) @(posedge clk_sys);
    rd(A_AX, 8'h01);
    chk({30'h0, rng}, 32'h3);
    repeat (200) @(posedge clk_sys);
  endtask : t_boost
  // Pins follow the chosen clock one cycle late, or the normal value
  task automatic pins(input logic [7:0] ax, input logic [7:0] sqc, input logic [1:0] src);
    logic c;
    logic [1:0] e;
    wr(A_AX, ax);
    wr(A_SQ, sqc);
    repeat (16)
    begin
      c = (src == 2'h0 ? ps : src == 2'h1 ? sq : src == 2'h2 ? osc : 1'b0) ^ ~sqc[6];
      e = {ax[7] && sqc[7] ? c : nrm[1], ax[6] && sqc[7] ? c : nrm[0]};
      nrm <= nrm + 2'h1;
      @(posedge clk_sys);
      chk({30'h0, pin}, {30'h0, e});
    end
  endtask : pins
  // Half period of the prescaler output
  task automatic phase(output int n);
    logic p;
    p = ps;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ps === p && n < 600);
  endtask : phase
  task automatic t_div;
    int n;
    for (int k = 0; k < 9; k++)
    begin
      wr(A_SQ, k == 8 ? 8'h08 : 8'(k));
      repeat (600) @(posedge clk_sys);
      phase(n);
      phase(n);
      chk(32'(n), k == 8 ? 32'h1 : 32'h1 << k);
    end
  endtask : t_div
  // Period and weight of the generator bit
  task automatic seqp(input logic [7:0] cfg, input int per, input int ones);
    logic b[$];
    int w;
    int d;
    wr(A_SQ, cfg);
    repeat (per + 40)
    begin
      @(posedge clk_sys);
      b.push_back(sq);
    end
    w = 0;
    d = 0;
    for (int i = 24; i < per + 24; i++)
      w += b[i];
    for (int i = 24; i < 40; i++)
      d += (b[i] !== b[i+per]);
    chk(32'(w), 32'(ones));
    chk(32'(d), 32'h0);
  endtask : seqp
  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    {reset_n, cyc, stb, we, kick} = 5'h00;
    ticks = 0;
    n_fail = 0;
    compares = 0;
    adr = 12'h000;
    sel = 4'h0;
    wdat = 32'h0;
    nrm = 2'h0;
    repeat (20) @(posedge clk_sys);
    chk({30'h0, oe_n}, 32'h3);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({30'h0, oe_n}, 32'h0);
    t_regs;
    wr(A_AX, 8'h01);
    t_boost;
    pins(8'hC1, 8'h08, 2'h0);
    pins(8'h41, 8'h88, 2'h0);
    pins(8'hCD, 8'hD8, 2'h1);
    pins(8'hC5, 8'hD8, 2'h0);
    pins(8'h91, 8'hD8, 2'h1);
    // Oscillator level goes high so its route is told apart from zero
    pulse;
    repeat (8) @(posedge clk_sys);
    pins(8'hA1, 8'hD8, 2'h2);
    pins(8'hB1, 8'h98, 2'h3);
    t_div;
    seqp(8'h18, 255, 128);
    seqp(8'h38, 4095, 2048);
    seqp(8'h10, 510, 256);
    wr(A_SQ, 8'h08);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, sq}, 32'h0);
    final_report;
  end
endmodule : tsc_clock_slew_test
